// [tb.sv]
// Self-checking bench for the wide timer capture block
`timescale 1ns/1ps
module tb;
  import wtd_pkg::*;
  logic       clk, rst, ce, wr, rd, pin_run, port2_bit0_pin, wide_timer_output, irq;
  logic [7:0] addr, wdata, rdata;
  int         n_errors, samples_checked, cycles;

  wtd_timer DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port2_bit0_pin(port2_bit0_pin), .wide_timer_output(wide_timer_output), .irq(irq));
  wtd_pin_model u_pin (.clk(clk), .rst(rst), .run(pin_run), .low_len(8'h14), .high_len(8'h0c),
    .pin(port2_bit0_pin));

  // Clock and hang guard
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, {8'h00, rdata}, {8'h00, exp});
  endtask

  // Write then read the same place back to back
  task automatic wr_rd(input string what, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr_reg(a, d);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, {8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic wait_toggle(output int n);
    logic o;
    #1;
    o = wide_timer_output;
    n = 0;
    while (wide_timer_output === o && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] offs [9];
    offs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
    foreach (offs[i]) rd_chk("reset value", offs[i], 8'h00);
    wr_rd("reload low", 8'h06, 8'ha5, 8'ha5);
    wr_rd("reload high", 8'h07, 8'h5a, 8'h5a);
    wr_rd("capture low", 8'h08, 8'h3c, 8'h00);
    wr_rd("capture high", 8'h09, 8'hc3, 8'h00);
    wr_rd("narrow capture", 8'h0a, 8'h77, 8'h00);
    rd_chk("unmapped", 8'h0f, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_single();
    wr_reg(8'h06, 8'h03); // Timer idle and count not one
    wr_reg(8'h07, 8'h00);
    wr_reg(8'h03, 8'h02);
    wr_reg(8'h00, 8'h80);
    repeat (12) @(posedge clk);
    #1;
    check("single toggle", {15'h0000, wide_timer_output}, 16'h0001);
    check("timeout irq", {15'h0000, irq}, 16'h0001);
    rd_chk("single stopped", 8'h00, 8'h00);
    rd_chk("timeout status", 8'h02, 8'h02);
    wr_reg(8'h04, 8'h03);
    #1;
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    $display("test single done");
  endtask

  task automatic t_modulo();
    int n;
    wr_reg(8'h00, 8'hc0);
    wait_toggle(n);
    wait_toggle(n);
    check("modulo period", n[15:0], 16'h0003);
    wait_toggle(n);
    check("modulo period again", n[15:0], 16'h0003);
    // Freeze with the output high; a live timer would toggle three times
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("frozen output", {15'h0000, wide_timer_output}, 16'h0001);
    @(posedge clk);
    ce <= 1'b1;
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h04, 8'h03);
    $display("test modulo done");
  endtask

  task automatic t_wrap();
    wr_reg(8'h06, 8'h00);
    wr_reg(8'h07, 8'h00);
    wr_reg(8'h00, 8'h80);
    repeat (40) @(posedge clk);
    rd_chk("wrap timeout", 8'h02, 8'h00);
    check("wrap irq", {15'h0000, irq}, 16'h0000);
    wr_reg(8'h00, 8'h00);
    $display("test wrap done");
  endtask

  task automatic t_demod();
    logic [7:0] ctl [3];
    logic [7:0] st [3];
    logic [7:0] cfg [3];
    ctl = '{8'h88, 8'h98, 8'ha8};
    st  = '{8'h01, 8'h02, 8'h03};
    cfg = '{8'h84, 8'h80, 8'hc4};
    wr_reg(8'h06, 8'hff);
    wr_reg(8'h07, 8'hff);
    wr_reg(8'h03, 8'h01);
    for (int s = 0; s < 3; s++) begin
      wr_reg(8'h00, 8'h03);
      wr_reg(8'h04, 8'h03);
      wr_reg(8'h01, cfg[s]);
      pin_run <= 1'b1;
      wr_reg(8'h00, ctl[s]);
      repeat (110) @(posedge clk);
      rd_chk("edge status", 8'h00, ctl[s] | st[s]);
      check("capture irq", {15'h0000, irq}, (s == 1) ? 16'h0000 : 16'h0001);
      if (s == 0) begin
        rd_chk("capture low", 8'h08, 8'h1f);
        rd_chk("capture high", 8'h09, 8'h00);
        rd_chk("narrow low time", 8'h0a, 8'h14);
      end
      if (s == 2) begin
        // Raw count; last capture is a fall eleven steps after all ones
        rd_chk("raw capture low", 8'h08, 8'hf4);
        rd_chk("raw capture high", 8'h09, 8'hff);
      end
      pin_run <= 1'b0;
      repeat (6) @(posedge clk);
    end
    // Pin not routed: a qualifying edge must not capture
    wr_reg(8'h00, 8'h03);
    wr_reg(8'h01, 8'h04);
    pin_run <= 1'b1;
    wr_reg(8'h00, 8'h88);
    repeat (40) @(posedge clk);
    rd_chk("unrouted pin", 8'h00, 8'h88);
    pin_run <= 1'b0;
    wr_reg(8'h00, 8'h03);
    $display("test demod done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst             = 1'b1;
    ce              = 1'b1;
    wr              = 1'b0;
    rd              = 1'b0;
    addr            = 8'h00;
    wdata           = 8'h00;
    pin_run         = 1'b0;
    n_errors        = 0;
    samples_checked = 0;
    cycles          = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_modulo();
    t_wrap();
    t_demod();
    finish_test();
  end
endmodule

// [wtd_edge_sync.sv]
// Two-flop pin synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module wtd_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Pin and detected edges
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // ---------------------------------------------------------------
  // Synchroniser and edge history
  // ---------------------------------------------------------------
  // Reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else if (ce) begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edges seen only on the second stage
  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
  assign fall  = ~sync_r & last_r;

endmodule

// [wtd_pin_model.sv]
// Modulated signal source on the capture pin
`timescale 1ns/1ps
module wtd_pin_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Waveform control
  input  wire logic       run,
  input  wire logic [7:0] low_len,
  input  wire logic [7:0] high_len,
  // Modulated signal
  output logic            pin
);
  logic [7:0] cnt_r;

  // Idles high like a pulled-up pin, square wave while run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin   <= 1'b1;
      cnt_r <= 8'h00;
    end else if (!run || cnt_r == (pin ? high_len : low_len) - 8'h01) begin
      pin   <= !run || !pin;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// [wtd_pkg.sv]
// Package of offsets, field positions, reset values and states for the wide timer capture block
package wtd_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] WTD_OFF_CTRL_A     = 8'h00;
  localparam logic [7:0] WTD_OFF_CTRL_B     = 8'h01;
  localparam logic [7:0] WTD_OFF_IRQ_STAT   = 8'h02;
  localparam logic [7:0] WTD_OFF_IRQ_EN     = 8'h03;
  localparam logic [7:0] WTD_OFF_IRQ_CLR    = 8'h04;
  localparam logic [7:0] WTD_OFF_RELOAD_LO  = 8'h06;
  localparam logic [7:0] WTD_OFF_RELOAD_HI  = 8'h07;
  localparam logic [7:0] WTD_OFF_CAP_LO     = 8'h08;
  localparam logic [7:0] WTD_OFF_CAP_HI     = 8'h09;
  localparam logic [7:0] WTD_OFF_NCAP       = 8'h0a;

  // ---------------------------------------------------------------
  // Field positions in timer_control_a
  // ---------------------------------------------------------------
  localparam int WTD_A_ENABLE  = 7;
  localparam int WTD_A_MODULO  = 6;
  localparam int WTD_A_EDGE_HI = 5;
  localparam int WTD_A_EDGE_LO = 4;
  localparam int WTD_A_DEMOD   = 3;
  localparam int WTD_A_FALL_ST = 1;
  localparam int WTD_A_RISE_ST = 0;

  // ---------------------------------------------------------------
  // Field positions in timer_control_b
  // ---------------------------------------------------------------
  localparam int WTD_B_PIN_ROUTE = 7;
  localparam int WTD_B_RAW_CAP   = 6;
  localparam int WTD_B_IEN       = 2;
  localparam int WTD_B_OUT_INIT  = 0;

  // ---------------------------------------------------------------
  // Interrupt status bit positions
  // ---------------------------------------------------------------
  localparam int WTD_IRQ_CAPTURE = 0;
  localparam int WTD_IRQ_TIMEOUT = 1;
  localparam int WTD_IRQ_BITS    = 2;

  // ---------------------------------------------------------------
  // Edge select encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  WTD_EDGE_RISE  = 2'h0;
  localparam logic [1:0]  WTD_EDGE_FALL  = 2'h1;
  localparam logic [1:0]  WTD_EDGE_BOTH  = 2'h2;
  localparam logic [7:0]  WTD_RST_BYTE   = 8'h00;
  localparam logic [15:0] WTD_ALL_ONES   = 16'hffff;
  localparam logic [15:0] WTD_TERMINAL   = 16'h0001;
  localparam logic [7:0]  WTD_NARROW_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timer sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    WTD_ST_IDLE  = 3'b000,
    WTD_ST_RUN   = 3'b001,
    WTD_ST_FIRST = 3'b010,
    WTD_ST_DEMOD = 3'b011
  } wtd_state_t;

endpackage

// [wtd_sva.sv]
// Port-level assertions for the wide timer capture block
`timescale 1ns/1ps
module wtd_timer_sva
  import wtd_pkg::*;
(
  // Clock and control
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Pin and outputs
  input wire logic       port2_bit0_pin,
  input wire logic       wide_timer_output,
  input wire logic       irq
);
  // ---------------------------------------------------------------
  // Shadow of the reload bytes
  // ---------------------------------------------------------------
  logic [15:0] hold_r;

  // Follow software writes to the hold bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      hold_r <= 16'h0000;
    else if (ce && wr && addr == 8'h06)
      hold_r[7:0] <= wdata;
    else if (ce && wr && addr == 8'h07)
      hold_r[15:8] <= wdata;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside an answer");
  chk_read_zero: assert property (rd && ce && (addr == 8'h04 || addr == 8'h0f) |=> rdata == 8'h00)
    else $error("unreadable place gave data");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wr))
    else $error("irq dropped without a write");
  chk_reload_lo: assert property (
    (ce && wr && addr == 8'h06) ##1 (rd && addr == 8'h06) |=> rdata == $past(wdata, 2))
    else $error("reload low byte readback wrong");
  chk_reload_hi: assert property (
    (ce && wr && addr == 8'h07) ##1 (rd && addr == 8'h07) |=> rdata == $past(wdata, 2))
    else $error("reload high byte readback wrong");
  chk_single_pass: assert property (
    ce && wr && addr == 8'h00 && wdata == 8'h80 && hold_r == 16'h0003
    |=> ##2 $stable(wide_timer_output) ##1 $changed(wide_timer_output) ##1 $stable(wide_timer_output) [*8])
    else $error("single pass toggle timing wrong");
  chk_modulo_n: assert property (
    ce && wr && addr == 8'h00 && wdata == 8'hc0 && hold_r == 16'h0003
    |=> ##3 $changed(wide_timer_output) ##1 $stable(wide_timer_output) [*2] ##1 $changed(wide_timer_output))
    else $error("modulo toggle period wrong");
  chk_zero_wrap: assert property (
    ce && wr && addr == 8'h00 && wdata == 8'h80 && hold_r == 16'h0000
    |=> ##1 $stable(wide_timer_output) [*8])
    else $error("zero count wrap toggled output");
endmodule

bind wtd_timer wtd_timer_sva u_sva (
  .clk               (clk),
  .rst               (rst),
  .ce                (ce),
  .addr              (addr),
  .wdata             (wdata),
  .wr                (wr),
  .rd                (rd),
  .rdata             (rdata),
  .port2_bit0_pin    (port2_bit0_pin),
  .wide_timer_output (wide_timer_output),
  .irq               (irq)
);

// [wtd_timer.sv]
// Wide down-counter with single-pass, modulo-N and demodulation capture modes
//
// Operation
// - Narrow timer count latched into narrow capture
// - High capture byte holds count MS byte
// - Low capture byte; capture writes ignored
// - Two read/write hold bytes give reload
// - Zero initial count wraps to all ones
// - Zero to all-ones wrap is no timeout
// - First qualifying edge captures, reloads, starts counting
// - Edge select picks rising, falling, both
// - Mode bit zero stores complemented count after the first capture
// - Each capture sets an edge status bit
// - Capture interrupt only when enable bit set
// - After capture reload all ones, restart
// - Port pin routable to edge detection
`timescale 1ns/1ps
module wtd_timer
  import wtd_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8,
  parameter int CNT_W  = 16,
  parameter int NCNT_W = 8
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Capture pin
  input  wire logic              port2_bit0_pin,
  // Outputs
  output logic                   wide_timer_output,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]       ctrl_a_r;
  logic [DATA_W-1:0]       ctrl_b_r;
  logic [DATA_W-1:0]       reload_lo_r;
  logic [DATA_W-1:0]       reload_hi_r;
  logic [DATA_W-1:0]       cap_lo_r;
  logic [DATA_W-1:0]       cap_hi_r;
  logic [DATA_W-1:0]       ncap_r;
  logic [WTD_IRQ_BITS-1:0] irq_stat_r;
  logic [WTD_IRQ_BITS-1:0] irq_en_r;
  logic [DATA_W-1:0]       rdata_r;

  // Counter state
  logic [CNT_W-1:0]        cnt_r;
  logic [CNT_W-1:0]        cnt_nxt;
  logic [NCNT_W-1:0]       ncnt_r;
  logic                    out_r;
  wtd_state_t              state_r;
  wtd_state_t              state_nxt;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire sel_ctrl_a  = (addr == ADDR_W'(WTD_OFF_CTRL_A));
  wire sel_ctrl_b  = (addr == ADDR_W'(WTD_OFF_CTRL_B));
  wire sel_stat    = (addr == ADDR_W'(WTD_OFF_IRQ_STAT));
  wire sel_en      = (addr == ADDR_W'(WTD_OFF_IRQ_EN));
  wire sel_clr     = (addr == ADDR_W'(WTD_OFF_IRQ_CLR));
  wire sel_rel_lo  = (addr == ADDR_W'(WTD_OFF_RELOAD_LO));
  wire sel_rel_hi  = (addr == ADDR_W'(WTD_OFF_RELOAD_HI));
  wire sel_cap_lo  = (addr == ADDR_W'(WTD_OFF_CAP_LO));
  wire sel_cap_hi  = (addr == ADDR_W'(WTD_OFF_CAP_HI));
  wire sel_ncap    = (addr == ADDR_W'(WTD_OFF_NCAP));

  // Write strobes per register
  wire wr_ctrl_a   = wr & sel_ctrl_a;
  wire wr_ctrl_b   = wr & sel_ctrl_b;
  wire wr_en       = wr & sel_en;
  wire wr_clr      = wr & sel_clr;
  wire wr_rel_lo   = wr & sel_rel_lo;
  wire wr_rel_hi   = wr & sel_rel_hi;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  wire       enabled    = ctrl_a_r[WTD_A_ENABLE];
  wire       modulo     = ctrl_a_r[WTD_A_MODULO];
  wire       demod      = ctrl_a_r[WTD_A_DEMOD];
  wire [1:0] edge_sel   = ctrl_a_r[WTD_A_EDGE_HI:WTD_A_EDGE_LO];
  wire       pin_route  = ctrl_b_r[WTD_B_PIN_ROUTE];
  wire       raw_cap    = ctrl_b_r[WTD_B_RAW_CAP];
  wire       cap_ien    = ctrl_b_r[WTD_B_IEN];
  wire       out_init   = ctrl_b_r[WTD_B_OUT_INIT];

  // Enable command: software sets the enable bit while it is clear
  wire       start      = wr_ctrl_a & wdata[WTD_A_ENABLE] & ~enabled;
  wire       stop_cmd   = wr_ctrl_a & ~wdata[WTD_A_ENABLE];

  // ---------------------------------------------------------------
  // Capture pin edges
  // ---------------------------------------------------------------
  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  wtd_edge_sync u_edge (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .pin   (port2_bit0_pin),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // Qualify edges by routing and edge select
  wire rise_ok  = pin_route & pin_rise &
                  ((edge_sel == WTD_EDGE_RISE) | (edge_sel == WTD_EDGE_BOTH));
  wire fall_ok  = pin_route & pin_fall &
                  ((edge_sel == WTD_EDGE_FALL) | (edge_sel == WTD_EDGE_BOTH));
  wire edge_ok  = rise_ok | fall_ok;

  // ---------------------------------------------------------------
  // Counter terms
  // ---------------------------------------------------------------
  wire [CNT_W-1:0] hold_val  = CNT_W'({reload_hi_r, reload_lo_r});
  wire [CNT_W-1:0] cnt_dec   = cnt_r - CNT_W'(1);
  // Reaching one means the next step would be zero: terminal count
  wire             terminal  = (cnt_r == CNT_W'(WTD_TERMINAL));
  wire             running   = (state_r == WTD_ST_RUN);
  wire             timeout   = running & terminal;
  wire             first_cap = (state_r == WTD_ST_FIRST) & edge_ok;
  wire             next_cap  = (state_r == WTD_ST_DEMOD) & edge_ok;
  wire             any_cap   = first_cap | next_cap;

  // Captured word: raw on the first capture, else complemented unless raw mode selected
  wire [CNT_W-1:0] cap_word  = (next_cap & ~raw_cap) ? ~cnt_r : cnt_r;

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WTD_ST_IDLE: begin
        if (start) begin
          state_nxt = (wdata[WTD_A_DEMOD]) ? WTD_ST_FIRST : WTD_ST_RUN;
        end
      end
      WTD_ST_RUN: begin
        if (stop_cmd) begin
          state_nxt = WTD_ST_IDLE;
        end else if (timeout & ~modulo) begin
          state_nxt = WTD_ST_IDLE;
        end
      end
      WTD_ST_FIRST: begin
        if (stop_cmd) begin
          state_nxt = WTD_ST_IDLE;
        end else if (edge_ok) begin
          state_nxt = WTD_ST_DEMOD;
        end
      end
      WTD_ST_DEMOD: begin
        if (stop_cmd) begin
          state_nxt = WTD_ST_IDLE;
        end
      end
      default: begin
        state_nxt = WTD_ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Counter next value
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      // Hold bytes must be stable here; software keeps off them
      cnt_nxt = hold_val;
    end else if (any_cap) begin
      cnt_nxt = CNT_W'(WTD_ALL_ONES);
    end else if (timeout) begin
      cnt_nxt = hold_val;
    end else if (running | (state_r == WTD_ST_DEMOD)) begin
      // Zero steps to all ones and keeps going
      cnt_nxt = cnt_dec;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and counter registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= WTD_ST_IDLE;
      cnt_r   <= CNT_W'(WTD_ALL_ONES);
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Narrow timer: counts while the input is low, restarts per capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ncnt_r <= NCNT_W'(WTD_NARROW_RST);
    end else if (ce) begin
      if (any_cap) begin
        ncnt_r <= NCNT_W'(WTD_NARROW_RST);
      end else if (~pin_level & (state_r == WTD_ST_DEMOD)) begin
        ncnt_r <= ncnt_r + NCNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture registers; software writes never reach them
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_lo_r <= WTD_RST_BYTE;
      cap_hi_r <= WTD_RST_BYTE;
      ncap_r   <= WTD_RST_BYTE;
    end else if (ce & any_cap) begin
      cap_hi_r <= cap_word[CNT_W-1:CNT_W-DATA_W];
      cap_lo_r <= cap_word[DATA_W-1:0];
      ncap_r   <= DATA_W'(ncnt_r);
    end
  end

  // ---------------------------------------------------------------
  // Hold registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_lo_r <= WTD_RST_BYTE;
      reload_hi_r <= WTD_RST_BYTE;
    end else if (ce) begin
      if (wr_rel_lo) begin
        reload_lo_r <= wdata;
      end
      if (wr_rel_hi) begin
        reload_hi_r <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register A: settings, enable and sticky edge status
  // ---------------------------------------------------------------
  // Edge status: set wins over a write-one clear in the same cycle
  wire rise_clr = wr_ctrl_a & wdata[WTD_A_RISE_ST];
  wire fall_clr = wr_ctrl_a & wdata[WTD_A_FALL_ST];
  wire rise_st  = (any_cap & rise_ok) |
                  (ctrl_a_r[WTD_A_RISE_ST] & ~rise_clr);
  wire fall_st  = (any_cap & fall_ok) |
                  (ctrl_a_r[WTD_A_FALL_ST] & ~fall_clr);
  // Enable drops by itself when a single pass ends
  wire en_nxt   = wr_ctrl_a ? wdata[WTD_A_ENABLE]
                            : (enabled & ~(timeout & ~modulo));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_r <= WTD_RST_BYTE;
    end else if (ce) begin
      ctrl_a_r[WTD_A_ENABLE]               <= en_nxt;
      ctrl_a_r[WTD_A_RISE_ST]              <= rise_st;
      ctrl_a_r[WTD_A_FALL_ST]              <= fall_st;
      if (wr_ctrl_a) begin
        ctrl_a_r[WTD_A_MODULO:WTD_A_DEMOD] <= wdata[WTD_A_MODULO:WTD_A_DEMOD];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register B
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_b_r <= WTD_RST_BYTE;
    end else if (ce & wr_ctrl_b) begin
      ctrl_b_r <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Timer output: initial level on start, toggles at terminal count
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r <= 1'b0;
    end else if (ce) begin
      if (start) begin
        out_r <= out_init;
      end else if (timeout) begin
        out_r <= ~out_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, enable and clear
  // ---------------------------------------------------------------
  logic [WTD_IRQ_BITS-1:0] irq_set;
  logic [WTD_IRQ_BITS-1:0] irq_clr;

  always_comb begin
    irq_set                  = '0;
    irq_set[WTD_IRQ_CAPTURE] = any_cap & cap_ien;
    irq_set[WTD_IRQ_TIMEOUT] = timeout;
    irq_clr                  = wr_clr ? wdata[WTD_IRQ_BITS-1:0] : '0;
  end

  // Set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end else if (ce) begin
      irq_stat_r <= irq_set | (irq_stat_r & ~irq_clr);
      if (wr_en) begin
        irq_en_r <= wdata[WTD_IRQ_BITS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux; unmapped and write-only offsets read zero
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] stat_rd = DATA_W'(irq_stat_r);
  wire [DATA_W-1:0] en_rd   = DATA_W'(irq_en_r);
  wire [DATA_W-1:0] rd_mux  =
      sel_ctrl_a ? ctrl_a_r    :
      sel_ctrl_b ? ctrl_b_r    :
      sel_stat   ? stat_rd     :
      sel_en     ? en_rd       :
      sel_rel_lo ? reload_lo_r :
      sel_rel_hi ? reload_hi_r :
      sel_cap_lo ? cap_lo_r    :
      sel_cap_hi ? cap_hi_r    :
      sel_ncap   ? ncap_r      : '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= rd ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata             = rdata_r;
  assign wide_timer_output = out_r;
  assign irq               = |(irq_stat_r & irq_en_r);

endmodule
